// *** inc/srm_regs.svh ***
// constants for the system register move unit
// assumes the pipeline hands over one decoded 0F-prefixed instruction at a time
//
// Contract
// - 0F 22 writes a general register into a control register; 0F 20 reads one.
// - every control and debug move is a full 32-bit move.
// - reg field picks control/debug register, r/m picks general register, mod is 11.
// - writing page_table_base_holder flushes all non-global translation entries.
// - changing any paging flag flushes all translation entries, global ones too.
// - with paging on, setting wide_physical_address_on loads directory pointer entries.
// - with wide addressing and paging on, base writes reload directory pointer entries.
// - with wide addressing on, setting paging_on reloads directory pointer entries.
// - arithmetic status flags are undefined after these moves and not checked.
// - protected mode at privilege level not 0 raises protection_fault, code 0.
// - setting a reserved extension_control_word bit raises protection_fault.
// - reserved bits in loaded directory pointer entries raise protection_fault, code 0.
// - virtual 8086 mode refuses every control and debug move with protection_fault.
// - 0F 21 reads a debug register; 0F 23 writes one, slots zero to seven.
// - debug moves only at privilege level 0 or in real-address mode.
// - with debug extensions off, alias slots a and b map to status and control words.
// - with debug extensions on, alias slots raise invalid_opcode_fault, nothing updated.
// - debug register access while debug_access_trap_on is set raises debug_trap.
`ifndef SRM_REGS_SVH
`define SRM_REGS_SVH
`define SRM_OP_CR_RD    8'h20
`define SRM_OP_DR_RD    8'h21
`define SRM_OP_CR_WR    8'h22
`define SRM_OP_DR_WR    8'h23
`define SRM_MOD_REG     2'h3
`define SRM_SEL_CR0     3'h0
`define SRM_SEL_CR2     3'h2
`define SRM_SEL_CR3     3'h3
`define SRM_SEL_CR4     3'h4
`define SRM_SEL_ALIAS_A 3'h4
`define SRM_SEL_ALIAS_B 3'h5
`define SRM_SEL_DSTAT   3'h6
`define SRM_SEL_DCTRL   3'h7
`define SRM_BIT_PROT    0
`define SRM_BIT_PAGING  31
`define SRM_BIT_DBGEXT  3
`define SRM_BIT_LARGE   4
`define SRM_BIT_WIDE    5
`define SRM_BIT_GLOBAL  7
`define SRM_BIT_GDTRAP  13
`define SRM_CR0_PAGEMSK 32'h8000_0001
`define SRM_CR4_PAGEMSK 32'h0000_00b0
`define SRM_CR4_RSVD    32'hffff_fe00
`define SRM_PTR_RSVD    32'h0000_01e6
`define SRM_PTR_PRESENT 0
`define SRM_CR0_RESET   32'h6000_0010
`define SRM_DSTAT_RESET 32'hffff_0ff0
`define SRM_DCTRL_RESET 32'h0000_0400
`define SRM_ERR_ZERO    16'h0000
`define SRM_A_CTRL      12'h000
`define SRM_A_STATUS    12'h004
`define SRM_A_CR0       12'h008
`define SRM_A_CR3       12'h00c
`define SRM_A_CR4       12'h010
`define SRM_CTRL_HOLD   0
`endif

// *** inc/srm_pkg.sv ***
// types shared by the system register move unit
// assumes srm_regs.svh supplies the numeric constants
package srm_pkg;
    typedef enum logic [1:0] {
        MODE_REAL,
        MODE_PROT,
        MODE_V86
    } srm_mode_t;

    typedef enum logic [1:0] {
        FLT_NONE,
        FLT_PROT,
        FLT_INVOP,
        FLT_DBG
    } srm_fault_t;

    typedef struct packed {
        logic [7:0]  op2;
        logic [7:0]  form;
        logic [31:0] gpr;
        logic [1:0]  cpl;
        srm_mode_t   mode;
    } srm_ins_t;

    typedef struct packed {
        logic        wr;
        logic [2:0]  idx;
        logic [31:0] data;
    } srm_res_t;

    typedef struct packed {
        logic        valid;
        srm_fault_t  kind;
        logic [15:0] code;
    } srm_flt_t;
endpackage

// *** rtl/srm_unit.sv ***
// executes control and debug register moves, with their faults and side effects
// assumes the pipeline holds ins until ins_ready, and memory answers ptr_rd_req once
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "srm_regs.svh"
module srm_unit #(
    parameter int PTR_N = 4
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ins_valid,
    output logic                   ins_ready,
    input  wire srm_pkg::srm_ins_t ins,
    output logic                   done,
    output srm_pkg::srm_res_t      res,
    output srm_pkg::srm_flt_t      flt,
    output logic                   flush_nonglobal,
    output logic                   flush_all,
    output logic                   ptr_rd_req,
    output logic [31:0]            ptr_rd_base,
    input  wire logic              ptr_rd_ack,
    input  wire logic [PTR_N*32-1:0] ptr_rd_data,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr
);
    if (PTR_N < 1 || PTR_N > 8) begin : g_bad_ptr_n
        $error("srm_unit: PTR_N out of range");
    end

    typedef enum logic [1:0] { ST_IDLE, ST_LOAD, ST_DONE } srm_st_t;
    srm_st_t state;

    logic [31:0] cr0, cr2, cr3, cr4;
    logic [31:0] dbg [8];
    logic [31:0] ptr_reg [PTR_N];
    logic [31:0] pend_val;
    logic [2:0]  pend_sel;
    logic        pend_flush_ng, pend_flush_all;
    logic        hold;
    srm_pkg::srm_fault_t last_kind;

    function automatic logic cr_exists(input logic [2:0] s);
        return s == `SRM_SEL_CR0 || s == `SRM_SEL_CR2 || s == `SRM_SEL_CR3 || s == `SRM_SEL_CR4;
    endfunction

    function automatic logic is_alias(input logic [2:0] s);
        return s == `SRM_SEL_ALIAS_A || s == `SRM_SEL_ALIAS_B;
    endfunction

    // decode of the offered instruction
    logic [1:0]  modf;
    logic [2:0]  regf, rmf, dsel;
    logic        is_crr, is_crw, is_drr, is_drw, is_cr, is_dr;
    logic        fire, de, gd;
    logic        pg_old, pae_old, pg_new, pae_new;
    logic        next_flush_ng, next_flush_all, need_load;
    logic [31:0] rd_val;
    srm_pkg::srm_fault_t fk;

    assign ins_ready = state == ST_IDLE && !hold;
    assign fire      = ins_valid && ins_ready;
    assign modf      = ins.form[7:6];
    assign regf      = ins.form[5:3];
    assign rmf       = ins.form[2:0];
    assign is_crr    = ins.op2 == `SRM_OP_CR_RD;
    assign is_crw    = ins.op2 == `SRM_OP_CR_WR;
    assign is_drr    = ins.op2 == `SRM_OP_DR_RD;
    assign is_drw    = ins.op2 == `SRM_OP_DR_WR;
    assign is_cr     = is_crr || is_crw;
    assign is_dr     = is_drr || is_drw;
    assign de        = cr4[`SRM_BIT_DBGEXT];
    assign gd        = dbg[`SRM_SEL_DCTRL][`SRM_BIT_GDTRAP];
    // legacy aliasing of slots a and b
    assign dsel = (!de && regf == `SRM_SEL_ALIAS_A) ? `SRM_SEL_DSTAT :
                  (!de && regf == `SRM_SEL_ALIAS_B) ? `SRM_SEL_DCTRL : regf;
    assign pg_old  = cr0[`SRM_BIT_PAGING];
    assign pae_old = cr4[`SRM_BIT_WIDE];
    assign pg_new  = (regf == `SRM_SEL_CR0) ? ins.gpr[`SRM_BIT_PAGING] : pg_old;
    assign pae_new = (regf == `SRM_SEL_CR4) ? ins.gpr[`SRM_BIT_WIDE] : pae_old;

    always_comb begin
        fk = srm_pkg::FLT_NONE;
        if (ins.mode == srm_pkg::MODE_V86) begin
            fk = srm_pkg::FLT_PROT;
        end else if (!(is_cr || is_dr) || modf != `SRM_MOD_REG) begin
            fk = srm_pkg::FLT_INVOP;
        end else if (is_cr && !cr_exists(regf)) begin
            fk = srm_pkg::FLT_INVOP;
        end else if (is_dr && de && is_alias(regf)) begin
            fk = srm_pkg::FLT_INVOP;
        end else if (ins.mode == srm_pkg::MODE_PROT && ins.cpl != 2'h0) begin
            fk = srm_pkg::FLT_PROT;
        end else if (is_dr && gd) begin
            fk = srm_pkg::FLT_DBG;
        end else if (is_crw && regf == `SRM_SEL_CR4 && |(ins.gpr & `SRM_CR4_RSVD)) begin
            fk = srm_pkg::FLT_PROT;
        end
    end

    always_comb begin
        rd_val = dbg[dsel];
        if (is_cr) begin
            if (regf == `SRM_SEL_CR0) begin
                rd_val = cr0;
            end else if (regf == `SRM_SEL_CR2) begin
                rd_val = cr2;
            end else if (regf == `SRM_SEL_CR3) begin
                rd_val = cr3;
            end else begin
                rd_val = cr4;
            end
        end
    end

    always_comb begin
        next_flush_ng  = 1'b0;
        next_flush_all = 1'b0;
        need_load      = 1'b0;
        if (is_crw) begin
            if (regf == `SRM_SEL_CR3) begin
                next_flush_ng = 1'b1;
                need_load     = pae_old && pg_old;
            end
            if (regf == `SRM_SEL_CR0) begin
                next_flush_all = |((cr0 ^ ins.gpr) & `SRM_CR0_PAGEMSK);
                need_load      = pae_old && pg_new;
            end
            if (regf == `SRM_SEL_CR4) begin
                next_flush_all = |((cr4 ^ ins.gpr) & `SRM_CR4_PAGEMSK);
                need_load      = pg_old && pae_new;
            end
        end
    end

    // loaded entries are checked only where present
    logic ptr_bad;
    always_comb begin
        ptr_bad = 1'b0;
        for (int i = 0; i < PTR_N; i++) begin
            if (ptr_rd_data[i*32 + `SRM_PTR_PRESENT] && |(ptr_rd_data[i*32 +: 32] & `SRM_PTR_RSVD)) begin
                ptr_bad = 1'b1;
            end
        end
    end

    logic commit_now, commit_load;
    assign commit_now  = fire && fk == srm_pkg::FLT_NONE && is_crw && !need_load;
    assign commit_load = state == ST_LOAD && ptr_rd_ack && !ptr_bad;

    // sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state          <= ST_IDLE;
            pend_val       <= 32'h0000_0000;
            pend_sel       <= 3'h0;
            pend_flush_ng  <= 1'b0;
            pend_flush_all <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (fire && fk == srm_pkg::FLT_NONE && is_crw && need_load) begin
                        state          <= ST_LOAD;
                        pend_val       <= ins.gpr;
                        pend_sel       <= regf;
                        pend_flush_ng  <= next_flush_ng;
                        pend_flush_all <= next_flush_all;
                    end
                end
                ST_LOAD: begin
                    if (ptr_rd_ack) begin
                        state <= ST_DONE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // pointer fetch: base is the table address after the write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_rd_req  <= 1'b0;
            ptr_rd_base <= 32'h0000_0000;
        end else if (fire && fk == srm_pkg::FLT_NONE && is_crw && need_load) begin
            ptr_rd_req  <= 1'b1;
            ptr_rd_base <= (regf == `SRM_SEL_CR3) ? ins.gpr : cr3;
        end else if (ptr_rd_ack) begin
            ptr_rd_req <= 1'b0;
        end
    end

    generate
        for (genvar g = 0; g < PTR_N; g++) begin : g_ptr
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ptr_reg[g] <= 32'h0000_0000;
                end else if (commit_load) begin
                    ptr_reg[g] <= ptr_rd_data[g*32 +: 32];
                end
            end
        end
    endgenerate

    // control registers: a faulting pointer load leaves them untouched
    logic [31:0] wval;
    logic [2:0]  wsel;
    assign wval = commit_load ? pend_val : ins.gpr;
    assign wsel = commit_load ? pend_sel : regf;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cr0 <= `SRM_CR0_RESET;
            cr2 <= 32'h0000_0000;
            cr3 <= 32'h0000_0000;
            cr4 <= 32'h0000_0000;
        end else if (commit_now || commit_load) begin
            if (wsel == `SRM_SEL_CR0) cr0 <= wval;
            if (wsel == `SRM_SEL_CR2) cr2 <= wval;
            if (wsel == `SRM_SEL_CR3) cr3 <= wval;
            if (wsel == `SRM_SEL_CR4) cr4 <= wval;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) dbg[i] <= 32'h0000_0000;
            dbg[`SRM_SEL_DSTAT] <= `SRM_DSTAT_RESET;
            dbg[`SRM_SEL_DCTRL] <= `SRM_DCTRL_RESET;
        end else if (fire && fk == srm_pkg::FLT_NONE && is_drw) begin
            dbg[dsel] <= ins.gpr;
        end
    end

    // answers to the pipeline, all registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done            <= 1'b0;
            res             <= '0;
            flt             <= '0;
            flush_nonglobal <= 1'b0;
            flush_all       <= 1'b0;
        end else begin
            done            <= (fire && !(fk == srm_pkg::FLT_NONE && is_crw && need_load)) ||
                               (state == ST_LOAD && ptr_rd_ack);
            res.wr          <= fire && fk == srm_pkg::FLT_NONE && (is_crr || is_drr);
            res.idx         <= rmf;
            res.data        <= rd_val;
            flt.valid       <= (fire && fk != srm_pkg::FLT_NONE) ||
                               (state == ST_LOAD && ptr_rd_ack && ptr_bad);
            flt.kind        <= (state == ST_LOAD) ? srm_pkg::FLT_PROT : fk;
            flt.code        <= `SRM_ERR_ZERO;
            flush_nonglobal <= commit_now ? next_flush_ng : (commit_load && pend_flush_ng);
            flush_all       <= commit_now ? next_flush_all : (commit_load && pend_flush_all);
        end
    end

    // apb: zero wait states, unmapped offsets answer with an error
    assign pready = 1'b1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold      <= 1'b0;
            last_kind <= srm_pkg::FLT_NONE;
        end else begin
            if (psel && penable && pwrite && paddr == `SRM_A_CTRL) hold <= pwdata[`SRM_CTRL_HOLD];
            if (fire && fk != srm_pkg::FLT_NONE) last_kind <= fk;
        end
    end

    always_comb begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        if (paddr == `SRM_A_CTRL) begin
            prdata[`SRM_CTRL_HOLD] = hold;
        end else if (paddr == `SRM_A_STATUS) begin
            prdata[1:0] = last_kind;
            prdata[3:2] = state;
        end else if (paddr == `SRM_A_CR0) begin
            prdata = cr0;
        end else if (paddr == `SRM_A_CR3) begin
            prdata = cr3;
        end else if (paddr == `SRM_A_CR4) begin
            prdata = cr4;
        end else begin
            pslverr = psel && penable;
        end
    end

    // status flags are not produced by this unit at all

    property p_v86;
        @(posedge pclk) disable iff (!presetn)
        fire && ins.mode == srm_pkg::MODE_V86 |=> flt.valid && flt.kind == srm_pkg::FLT_PROT && !res.wr;
    endproperty
    a_v86: assert property (p_v86) else $error("v86 move not refused");

    property p_cpl;
        @(posedge pclk) disable iff (!presetn)
        fire && ins.mode == srm_pkg::MODE_PROT && ins.cpl != 2'h0 |=> flt.valid && flt.code == 16'h0000;
    endproperty
    a_cpl: assert property (p_cpl) else $error("privilege check missed");

    property p_alias;
        @(posedge pclk) disable iff (!presetn)
        fire && is_dr && de && is_alias(regf) && ins.mode != srm_pkg::MODE_V86
        |=> flt.kind == srm_pkg::FLT_INVOP && !res.wr;
    endproperty
    a_alias: assert property (p_alias) else $error("alias slot not refused");

    property p_rsvd;
        @(posedge pclk) disable iff (!presetn)
        commit_now |-> !(wsel == `SRM_SEL_CR4 && |(wval & `SRM_CR4_RSVD));
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit accepted");

    property p_base_flush;
        @(posedge pclk) disable iff (!presetn)
        commit_now && regf == `SRM_SEL_CR3 |=> flush_nonglobal && cr3 == $past(ins.gpr);
    endproperty
    a_base_flush: assert property (p_base_flush) else $error("base write did not flush");

    property p_req_hold;
        @(posedge pclk) disable iff (!presetn)
        ptr_rd_req && !ptr_rd_ack |=> ptr_rd_req && $stable(ptr_rd_base);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("pointer request dropped");

    property p_bad_ptr;
        @(posedge pclk) disable iff (!presetn)
        state == ST_LOAD && ptr_rd_ack && ptr_bad |=> flt.valid && $stable(cr0) && $stable(cr3) && $stable(cr4);
    endproperty
    a_bad_ptr: assert property (p_bad_ptr) else $error("bad pointer entry committed");

    property p_read;
        @(posedge pclk) disable iff (!presetn)
        fire && fk == srm_pkg::FLT_NONE && is_crr |=> res.wr && res.data == $past(rd_val) && done;
    endproperty
    a_read: assert property (p_read) else $error("read result wrong");

    property p_gd;
        @(posedge pclk) disable iff (!presetn)
        fire && is_dr && gd && ins.mode == srm_pkg::MODE_REAL && !(de && is_alias(regf)) && modf == `SRM_MOD_REG
        |=> flt.valid && flt.kind == srm_pkg::FLT_DBG && !res.wr && done;
    endproperty
    a_gd: assert property (p_gd) else $error("debug trap missed");
endmodule // srm_unit

// *** sim/srm_ptr_mem.sv ***
// pointer-table memory model that answers the unit's directory pointer fetch
// assumes the request is held until ack and falls at the edge after the ack
`timescale 1ns/1ps
module srm_ptr_mem #(
    parameter int PTR_N = 4
) (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           ptr_rd_req,
    input  wire logic [31:0]    ptr_rd_base,
    input  wire logic           slow,
    input  wire logic           bad,
    output logic                ptr_rd_ack,
    output logic [PTR_N*32-1:0] ptr_rd_data
);
    logic [3:0] wait_cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_rd_ack  <= 1'b0;
            ptr_rd_data <= '0;
            wait_cnt    <= 4'h0;
        end else if (ptr_rd_req && !ptr_rd_ack && wait_cnt >= (slow ? 4'h6 : 4'h0)) begin
            ptr_rd_ack <= 1'b1;
            wait_cnt   <= 4'h0;
            for (int i = 0; i < PTR_N; i++) begin
                ptr_rd_data[i*32+:32] <= {ptr_rd_base[31:12] + 20'(i), 12'h001};
            end
            // a bad table sets a reserved bit in a present entry
            if (bad) begin
                ptr_rd_data[31:0] <= {ptr_rd_base[31:12], 12'h003};
            end
        end else begin
            ptr_rd_ack  <= 1'b0;
            // outside the ack cycle the entries are inverted every cycle, so stale ones come back every other cycle
            ptr_rd_data <= ~ptr_rd_data;
            wait_cnt    <= ptr_rd_req ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule // srm_ptr_mem

// *** sim/system_register_move_unit_test.sv ***
// self-checking bench for srm_unit: moves, faults, pointer loads and the APB view
// assumes srm_ptr_mem answers pointer fetches and the unit answers APB with zero wait
`timescale 1ns/1ps
`include "srm_regs.svh"
module system_register_move_unit_test;
    logic                pclk, presetn, ins_valid, ins_ready, done, flush_nonglobal, flush_all;
    logic                ptr_rd_req, ptr_rd_ack, psel, penable, pwrite, pready, pslverr, slow, bad;
    logic [31:0]         ptr_rd_base, pwdata, prdata, rdat, got_base, v, cr3v;
    logic [127:0]        ptr_rd_data;
    logic [11:0]         paddr;
    logic                rerr, got_fng, got_fall, got_load;
    logic [31:0]         dr [8];
    srm_pkg::srm_ins_t   ins;
    srm_pkg::srm_res_t   res, got_res;
    srm_pkg::srm_flt_t   flt, got_flt;
    int                  fails, checks_done, cyc, seed;

    srm_unit #(.PTR_N(4)) dut_u (.pclk(pclk), .presetn(presetn), .ins_valid(ins_valid), .ins_ready(ins_ready),
        .ins(ins), .done(done), .res(res), .flt(flt), .flush_nonglobal(flush_nonglobal), .flush_all(flush_all),
        .ptr_rd_req(ptr_rd_req), .ptr_rd_base(ptr_rd_base), .ptr_rd_ack(ptr_rd_ack), .ptr_rd_data(ptr_rd_data),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    srm_ptr_mem #(.PTR_N(4)) mem_u (.pclk(pclk), .presetn(presetn), .ptr_rd_req(ptr_rd_req),
        .ptr_rd_base(ptr_rd_base), .slow(slow), .bad(bad), .ptr_rd_ack(ptr_rd_ack), .ptr_rd_data(ptr_rd_data));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic [2:0] slot(input logic [2:0] s);
        return (s == `SRM_SEL_ALIAS_A || s == `SRM_SEL_ALIAS_B) ? s + 3'h2 : s;
    endfunction

    task automatic chk_w(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_f(input srm_pkg::srm_fault_t k);
        checks_done++;
        if (k == srm_pkg::FLT_NONE ? got_flt.valid !== 1'b0 : got_flt !== {1'b1, k, `SRM_ERR_ZERO}) begin
            fails++;
            $display("[FAIL] fault expected %0d seen %h", k, got_flt);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    task automatic exec(input logic [7:0] op, input logic [1:0] md, input logic [2:0] sel, input logic [2:0] rm,
                        input logic [31:0] gpr, input logic [1:0] cpl, input srm_pkg::srm_mode_t mode);
        int n;
        n = 0;
        @(posedge pclk);
        ins       <= '{op2: op, form: {md, sel, rm}, gpr: gpr, cpl: cpl, mode: mode};
        ins_valid <= 1'b1;
        @(negedge pclk);
        while (ins_ready !== 1'b1 && n < 50) begin
            @(negedge pclk);
            n++;
        end
        @(posedge pclk);
        ins_valid <= 1'b0;
        got_load = 1'b0;
        do begin
            @(negedge pclk);
            n++;
            if (ptr_rd_req === 1'b1) begin
                got_load = 1'b1;
                got_base = ptr_rd_base;
            end
        end while (done !== 1'b1 && n < 100);
        chk_w("done", 32'h1, 32'(done));
        got_res  = res;
        got_flt  = flt;
        got_fng  = flush_nonglobal;
        got_fall = flush_all;
    endtask

    task automatic rd(input logic [7:0] op, input logic [2:0] sel, input logic [31:0] exp);
        logic [2:0] rm;
        rm = 3'($urandom);
        exec(op, `SRM_MOD_REG, sel, rm, $urandom, 2'h0, srm_pkg::MODE_REAL);
        chk_f(srm_pkg::FLT_NONE);
        chk_w("read wr", 32'h1, 32'(got_res.wr));
        chk_w("read idx", 32'(rm), 32'(got_res.idx));
        chk_w("read data", exp, got_res.data);
    endtask

    task automatic wr(input logic [7:0] op, input logic [2:0] sel, input logic [31:0] val);
        exec(op, `SRM_MOD_REG, sel, 3'($urandom), val, 2'h0, srm_pkg::MODE_REAL);
        chk_f(srm_pkg::FLT_NONE);
    endtask

    task automatic bad_mv(input logic [7:0] op, input logic [1:0] md, input logic [2:0] sel, input logic [31:0] g,
                          input logic [1:0] cpl, input srm_pkg::srm_mode_t mode, input srm_pkg::srm_fault_t k);
        exec(op, md, sel, 3'($urandom), g, cpl, mode);
        chk_f(k);
        chk_w("faulted wr", 32'h0, 32'(got_res.wr));
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    initial begin
        {presetn, ins_valid, psel, penable, pwrite, slow, bad} = '0;
        {ins, paddr, pwdata} = '0;
        {fails, checks_done, cyc} = '0;
        seed = $urandom(72);
        do_reset();
        rd(`SRM_OP_CR_RD, `SRM_SEL_CR0, `SRM_CR0_RESET);
        rd(`SRM_OP_DR_RD, `SRM_SEL_DCTRL, `SRM_DCTRL_RESET);
        apb(1'b1, `SRM_A_CR0, $urandom);
        apb(1'b0, `SRM_A_CR0, 32'h0);
        chk_w("apb cr0", `SRM_CR0_RESET, rdat);
        apb(1'b0, 12'h020, 32'h0);
        chk_w("apb unmapped", 32'h1, 32'(rerr));
        apb(1'b1, `SRM_A_CTRL, 32'h1);
        @(negedge pclk);
        chk_w("held ready", 32'h0, 32'(ins_ready));
        apb(1'b1, `SRM_A_CTRL, 32'h0);
        $display("test reset_and_apb done");
        for (int i = 0; i < 8; i++) begin
            v = $urandom;
            v[`SRM_BIT_GDTRAP] = 1'b0;
            wr(`SRM_OP_DR_WR, 3'(i), v);
            dr[slot(3'(i))] = v;
            rd(`SRM_OP_DR_RD, 3'(i), dr[slot(3'(i))]);
        end
        rd(`SRM_OP_DR_RD, `SRM_SEL_DSTAT, dr[6]);
        v = $urandom;
        wr(`SRM_OP_CR_WR, `SRM_SEL_CR2, v);
        rd(`SRM_OP_CR_RD, `SRM_SEL_CR2, v);
        cr3v = $urandom & 32'hffff_ffe0;
        wr(`SRM_OP_CR_WR, `SRM_SEL_CR3, cr3v);
        chk_w("flush ng", 32'h1, 32'(got_fng));
        chk_w("flush all", 32'h0, 32'(got_fall));
        rd(`SRM_OP_CR_RD, `SRM_SEL_CR3, cr3v);
        $display("test clean_moves done");
        bad_mv(`SRM_OP_CR_RD, `SRM_MOD_REG, `SRM_SEL_CR0, 0, 2'h3, srm_pkg::MODE_PROT, srm_pkg::FLT_PROT);
        bad_mv(`SRM_OP_DR_RD, `SRM_MOD_REG, 3'h0, 0, 2'h1, srm_pkg::MODE_PROT, srm_pkg::FLT_PROT);
        bad_mv(`SRM_OP_CR_RD, `SRM_MOD_REG, `SRM_SEL_CR0, 0, 2'h0, srm_pkg::MODE_V86, srm_pkg::FLT_PROT);
        bad_mv(`SRM_OP_DR_WR, `SRM_MOD_REG, 3'h1, 0, 2'h0, srm_pkg::MODE_V86, srm_pkg::FLT_PROT);
        bad_mv(`SRM_OP_CR_RD, 2'h0, `SRM_SEL_CR0, 0, 2'h0, srm_pkg::MODE_REAL, srm_pkg::FLT_INVOP);
        bad_mv(`SRM_OP_CR_WR, `SRM_MOD_REG, `SRM_SEL_CR4, 32'h200 << 5'($urandom % 23), 2'h0,
               srm_pkg::MODE_REAL, srm_pkg::FLT_PROT);
        bad_mv(`SRM_OP_CR_WR, `SRM_MOD_REG, `SRM_SEL_CR4, 32'h8000_0000, 2'h0,
               srm_pkg::MODE_PROT, srm_pkg::FLT_PROT);
        apb(1'b0, `SRM_A_STATUS, 32'h0);
        chk_w("status kind", 32'h1, 32'(rdat[1:0]));
        rd(`SRM_OP_CR_RD, `SRM_SEL_CR4, 32'h0);
        exec(`SRM_OP_DR_RD, `SRM_MOD_REG, 3'h2, 3'h0, 0, 2'h3, srm_pkg::MODE_REAL);
        chk_f(srm_pkg::FLT_NONE);
        $display("test faults done");
        wr(`SRM_OP_CR_WR, `SRM_SEL_CR4, 32'h8);
        bad_mv(`SRM_OP_DR_RD, `SRM_MOD_REG, `SRM_SEL_ALIAS_A, 0, 2'h0, srm_pkg::MODE_REAL, srm_pkg::FLT_INVOP);
        bad_mv(`SRM_OP_DR_WR, `SRM_MOD_REG, `SRM_SEL_ALIAS_B, 0, 2'h0, srm_pkg::MODE_PROT, srm_pkg::FLT_INVOP);
        rd(`SRM_OP_DR_RD, `SRM_SEL_DCTRL, dr[7]);
        wr(`SRM_OP_CR_WR, `SRM_SEL_CR4, 32'h18);
        chk_w("pse flush", 32'h1, 32'(got_fall));
        wr(`SRM_OP_CR_WR, `SRM_SEL_CR4, 32'h18);
        chk_w("same flush", 32'h0, 32'(got_fall));
        wr(`SRM_OP_CR_WR, `SRM_SEL_CR4, 32'h38);
        chk_w("pae no load", 32'h0, 32'(got_load));
        slow <= 1'b1;
        wr(`SRM_OP_CR_WR, `SRM_SEL_CR0, `SRM_CR0_RESET | `SRM_CR0_PAGEMSK);
        chk_w("pg load base", cr3v, got_base);
        chk_w("pg flush", 32'h1, 32'(got_fall));
        rd(`SRM_OP_CR_RD, `SRM_SEL_CR0, `SRM_CR0_RESET | `SRM_CR0_PAGEMSK);
        slow <= 1'b0;
        cr3v = $urandom & 32'hffff_ffe0;
        wr(`SRM_OP_CR_WR, `SRM_SEL_CR3, cr3v);
        chk_w("base load", cr3v, got_base);
        chk_w("base flush", 32'h1, 32'(got_fng));
        wr(`SRM_OP_CR_WR, `SRM_SEL_CR4, 32'h38);
        chk_w("pae load", 32'h1, 32'(got_load));
        chk_w("pae flush", 32'h0, 32'(got_fall));
        bad <= 1'b1;
        bad_mv(`SRM_OP_CR_WR, `SRM_MOD_REG, `SRM_SEL_CR3, 32'h0005_5000, 2'h0,
               srm_pkg::MODE_PROT, srm_pkg::FLT_PROT);
        bad <= 1'b0;
        rd(`SRM_OP_CR_RD, `SRM_SEL_CR3, cr3v);
        $display("test paging_side_effects done");
        wr(`SRM_OP_DR_WR, `SRM_SEL_DCTRL, dr[7] | 32'h2000);
        bad_mv(`SRM_OP_DR_RD, `SRM_MOD_REG, 3'h0, 0, 2'h0, srm_pkg::MODE_REAL, srm_pkg::FLT_DBG);
        bad_mv(`SRM_OP_DR_WR, `SRM_MOD_REG, 3'h3, 0, 2'h0, srm_pkg::MODE_PROT, srm_pkg::FLT_DBG);
        do_reset();
        rd(`SRM_OP_DR_RD, `SRM_SEL_DCTRL, `SRM_DCTRL_RESET);
        $display("test debug_trap done");
        tally_and_finish();
    end
endmodule // system_register_move_unit_test
